// >>> rtl/dog_timeout_reset_flag_defs.svh
/*
  Constants of the watchdog and reset-cause block: register offsets, bit
  positions, reset values and timing counts.
  Assumes inclusion by bare name from any design file that needs them.
*/
`ifndef DOG_TIMEOUT_RESET_FLAG_DEFS_SVH
`define DOG_TIMEOUT_RESET_FLAG_DEFS_SVH

`define DOG_TIMEOUT_RESET_FLAG_ADDR_W        8
`define DOG_TIMEOUT_RESET_FLAG_OFS_STATUS    8'h00
`define DOG_TIMEOUT_RESET_FLAG_OFS_CONTROL   8'h04

`define DOG_TIMEOUT_RESET_FLAG_BIT_DBG       4
`define DOG_TIMEOUT_RESET_FLAG_BIT_DOG       3
`define DOG_TIMEOUT_RESET_FLAG_BIT_BOR       2
`define DOG_TIMEOUT_RESET_FLAG_BIT_PIN       1
`define DOG_TIMEOUT_RESET_FLAG_BIT_POR       0
`define DOG_TIMEOUT_RESET_FLAG_BIT_UNLOCK    4
`define DOG_TIMEOUT_RESET_FLAG_BIT_ENABLE    3
`define DOG_TIMEOUT_RESET_FLAG_SEL_HI        2
`define DOG_TIMEOUT_RESET_FLAG_SEL_LO        0

`define DOG_TIMEOUT_RESET_FLAG_FLAGS_RST     5'h01
`define DOG_TIMEOUT_RESET_FLAG_SEL_RST       3'h0

`define DOG_TIMEOUT_RESET_FLAG_UNLOCK_CYCLES 3'h4
`define DOG_TIMEOUT_RESET_FLAG_CLK_HZ        40_000_000
`define DOG_TIMEOUT_RESET_FLAG_OSC_HZ        1_000_000
`define DOG_TIMEOUT_RESET_FLAG_BASE_CYCLES   16384
`define DOG_TIMEOUT_RESET_FLAG_CNT_W         21

`endif

// >>> rtl/dog_timeout_reset_flag_pkg.sv
/*
  Types of the watchdog and reset-cause block: APB carriers and the state
  record of the top module.
  Assumes dog_timeout_reset_flag_defs.svh is on the include path.
*/
`include "dog_timeout_reset_flag_defs.svh"

package dog_timeout_reset_flag_pkg;

  typedef struct packed {
    logic                      psel;
    logic                      penable;
    logic                      pwrite;
    logic [`DOG_TIMEOUT_RESET_FLAG_ADDR_W-1:0]   paddr;
    logic [31:0]               pwdata;
  } dog_timeout_reset_flag_apb_req_t;

  typedef struct packed {
    logic                      pready;
    logic                      pslverr;
    logic [31:0]               prdata;
  } dog_timeout_reset_flag_apb_rsp_t;

  typedef struct packed {
    logic                      dbg;
    logic                      bor;
    logic                      ext;
    logic                      por;
  } dog_timeout_reset_flag_src_t;

  typedef struct packed {
    dog_timeout_reset_flag_apb_rsp_t             rsp;
    logic [4:0]                flags;
    logic                      level2;
    logic                      enable;
    logic [2:0]                unlock_ctr;
    logic [2:0]                sel;
    logic [`DOG_TIMEOUT_RESET_FLAG_CNT_W-1:0]    count;
    logic                      osc_prev;
    logic                      wdt_pulse;
  } dog_timeout_reset_flag_state_t;

endpackage : dog_timeout_reset_flag_pkg

// >>> rtl/dog_timeout_reset_flag_sync.sv
/*
  Two-stage synchroniser for a group of pins.
  Assumes the inputs are levels that stay stable for several clock periods.
*/
module dog_timeout_reset_flag_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] stage1;

  if (WIDTH < 1) begin : g_bad_width
    $error("dog_timeout_reset_flag_sync needs at least one bit");
  end

  always_ff @(posedge clk) begin
    stage1 <= din;
    dout   <= stage1;
  end

endmodule : dog_timeout_reset_flag_sync

// >>> rtl/dog_timeout_reset_flag_top.sv
/*
  Watchdog timer with a protected control register and a reset-cause
  status register, reached over APB.
  Assumes the reset sources, the watchdog oscillator and the safety fuse
  arrive as asynchronous levels, and the restart strobe comes from the
  processor on clk.
*/
// Overview of operation
// - Debug-port reset sets status bit 4.
// - Watchdog reset sets status bit 3.
// - Brown-out reset sets status bit 2.
// - Pin reset sets status bit 1.
// - Power-on reset sets status bit 0.
// - Power-on or zero write clears bits 4..1.
// - Power-on flag cleared only by zero write.
// - Counter advances on separate 1 MHz oscillator.
// - Restart instruction zeroes the count.
// - Disable or chip reset zeroes count.
// - Expiry without restart resets the chip.
// - Fuse selects safety level one or two.
// - Level two never disables the watchdog.
// - Enable bit 3 enables or disables.
// - Disable needs unlock bit currently set.
// - Unlock bit self-clears after four cycles.
// - Period change only while unlock set.
// - Select code doubles timeout from 16K.
// - Expiry gives one-cycle reset pulse.
// - Level one enables without unlock.
// - Level two reads enable as one.
// - Level two second write updates period only.
`include "dog_timeout_reset_flag_defs.svh"

module dog_timeout_reset_flag_top #(
  parameter int BASE_CYCLES = `DOG_TIMEOUT_RESET_FLAG_BASE_CYCLES
) (
  input  wire logic                   clk,
  input  wire logic                   rst,
  input  wire dog_timeout_reset_flag_pkg::dog_timeout_reset_flag_apb_req_t apb_req,
  output dog_timeout_reset_flag_pkg::dog_timeout_reset_flag_apb_rsp_t      apb_rsp,
  input  wire dog_timeout_reset_flag_pkg::dog_timeout_reset_flag_src_t     reset_sources,
  input  wire logic                   watchdog_osc,
  input  wire logic                   safety_level_fuse,
  input  wire logic                   timer_restart_instruction,
  output logic                        watchdog_reset_pulse
);

  localparam int CNT_W    = `DOG_TIMEOUT_RESET_FLAG_CNT_W;
  localparam int CLK_PER_OSC = `DOG_TIMEOUT_RESET_FLAG_CLK_HZ / `DOG_TIMEOUT_RESET_FLAG_OSC_HZ;
  localparam logic [CNT_W:0] BASE_W = (CNT_W+1)'(BASE_CYCLES);

  // The oscillator is sampled, so it must be slow enough to show both levels.
  if (CLK_PER_OSC < 4) begin : g_bad_osc
    $error("watchdog oscillator too fast for the system clock");
  end
  if (BASE_CYCLES < 1 || BASE_CYCLES > `DOG_TIMEOUT_RESET_FLAG_BASE_CYCLES) begin : g_bad_base
    $error("BASE_CYCLES out of range for the counter width");
  end

  dog_timeout_reset_flag_pkg::dog_timeout_reset_flag_state_t s;
  dog_timeout_reset_flag_pkg::dog_timeout_reset_flag_state_t next_s;
  dog_timeout_reset_flag_pkg::dog_timeout_reset_flag_src_t   src_s;
  logic                  osc_s;
  logic                  fuse_s;
  logic [CNT_W:0]        limit;
  logic [CNT_W:0]        term;
  logic                  osc_rise;
  logic                  chip_rst;
  logic                  unlock_on;
  logic                  access;
  logic                  take;
  logic                  hit;
  logic                  wr_stat;
  logic                  wr_ctrl;
  logic [31:0]           rd_word;

  dog_timeout_reset_flag_sync #(
    .WIDTH (6)
  ) u_sync (
    .clk  (clk),
    .din  ({reset_sources, watchdog_osc, safety_level_fuse}),
    .dout ({src_s, osc_s, fuse_s})
  );

  assign apb_rsp              = s.rsp;
  assign watchdog_reset_pulse = s.wdt_pulse;

  always_comb begin
    next_s    = s;
    osc_rise  = osc_s & ~s.osc_prev;
    unlock_on = s.unlock_ctr != 3'h0;
    chip_rst  = src_s.dbg | src_s.bor | src_s.ext | src_s.por | s.wdt_pulse;
    limit     = BASE_W << s.sel;
    term      = limit - (CNT_W+1)'(1);
    access    = apb_req.psel & apb_req.penable;
    take      = access & s.rsp.pready;
    hit       = apb_req.paddr == `DOG_TIMEOUT_RESET_FLAG_OFS_STATUS || apb_req.paddr == `DOG_TIMEOUT_RESET_FLAG_OFS_CONTROL;
    wr_stat   = take & apb_req.pwrite & (apb_req.paddr == `DOG_TIMEOUT_RESET_FLAG_OFS_STATUS);
    wr_ctrl   = take & apb_req.pwrite & (apb_req.paddr == `DOG_TIMEOUT_RESET_FLAG_OFS_CONTROL);
    rd_word   = 32'h0000_0000;
    if (apb_req.paddr == `DOG_TIMEOUT_RESET_FLAG_OFS_STATUS) begin
      rd_word[4:0] = s.flags;
    end else if (apb_req.paddr == `DOG_TIMEOUT_RESET_FLAG_OFS_CONTROL) begin
      rd_word[`DOG_TIMEOUT_RESET_FLAG_BIT_UNLOCK]          = unlock_on;
      rd_word[`DOG_TIMEOUT_RESET_FLAG_BIT_ENABLE]          = s.enable | s.level2;
      rd_word[`DOG_TIMEOUT_RESET_FLAG_SEL_HI:`DOG_TIMEOUT_RESET_FLAG_SEL_LO] = s.sel;
    end

    // Bus slave: one wait state, answer registered so the outputs are flops.
    next_s.rsp.pready  = 1'b0;
    next_s.rsp.pslverr = 1'b0;
    if (access & ~s.rsp.pready) begin
      next_s.rsp.pready  = 1'b1;
      next_s.rsp.pslverr = ~hit;
      next_s.rsp.prdata  = apb_req.pwrite ? 32'h0000_0000 : rd_word;
    end

    if (unlock_on) begin
      next_s.unlock_ctr = s.unlock_ctr - 3'h1;
    end

    if (wr_ctrl) begin
      if (apb_req.pwdata[`DOG_TIMEOUT_RESET_FLAG_BIT_UNLOCK] & apb_req.pwdata[`DOG_TIMEOUT_RESET_FLAG_BIT_ENABLE]) begin
        next_s.unlock_ctr = `DOG_TIMEOUT_RESET_FLAG_UNLOCK_CYCLES;
      end
      if (s.level2) begin
        next_s.enable = 1'b1;
      end else if (apb_req.pwdata[`DOG_TIMEOUT_RESET_FLAG_BIT_ENABLE]) begin
        next_s.enable = 1'b1;
      end else if (unlock_on) begin
        next_s.enable = 1'b0;
      end
      if (unlock_on) begin
        next_s.sel = apb_req.pwdata[`DOG_TIMEOUT_RESET_FLAG_SEL_HI:`DOG_TIMEOUT_RESET_FLAG_SEL_LO];
      end
    end

    next_s.osc_prev  = osc_s;
    next_s.wdt_pulse = 1'b0;
    if (chip_rst | timer_restart_instruction | ~s.enable) begin
      next_s.count = '0;
    end else if (osc_rise) begin
      // A period shortened in mid-count still expires at the next tick.
      if ({1'b0, s.count} >= term) begin
        next_s.count     = '0;
        next_s.wdt_pulse = 1'b1;
      end else begin
        next_s.count = s.count + CNT_W'(1);
      end
    end

    // A chip reset restores the control register to its fuse-given state.
    if (chip_rst) begin
      next_s.enable     = s.level2;
      next_s.sel        = `DOG_TIMEOUT_RESET_FLAG_SEL_RST;
      next_s.unlock_ctr = 3'h0;
    end

    // Clears first, then sets, so an event in a clearing cycle is kept.
    if (src_s.por) begin
      next_s.flags[4:1] = 4'h0;
    end
    if (wr_stat) begin
      next_s.flags = next_s.flags & apb_req.pwdata[4:0];
    end
    next_s.flags[`DOG_TIMEOUT_RESET_FLAG_BIT_DBG] = next_s.flags[`DOG_TIMEOUT_RESET_FLAG_BIT_DBG] | src_s.dbg;
    next_s.flags[`DOG_TIMEOUT_RESET_FLAG_BIT_DOG] = next_s.flags[`DOG_TIMEOUT_RESET_FLAG_BIT_DOG] | next_s.wdt_pulse;
    next_s.flags[`DOG_TIMEOUT_RESET_FLAG_BIT_BOR] = next_s.flags[`DOG_TIMEOUT_RESET_FLAG_BIT_BOR] | src_s.bor;
    next_s.flags[`DOG_TIMEOUT_RESET_FLAG_BIT_PIN] = next_s.flags[`DOG_TIMEOUT_RESET_FLAG_BIT_PIN] | src_s.ext;
    next_s.flags[`DOG_TIMEOUT_RESET_FLAG_BIT_POR] = next_s.flags[`DOG_TIMEOUT_RESET_FLAG_BIT_POR] | src_s.por;

    if (rst) begin
      next_s        = '0;
      next_s.flags  = `DOG_TIMEOUT_RESET_FLAG_FLAGS_RST;
      next_s.level2 = fuse_s;
      next_s.enable = fuse_s;
      next_s.osc_prev = osc_s;
    end
  end

  always_ff @(posedge clk) begin
    s <= next_s;
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  property p_dbg_flag;
    src_s.dbg |=> s.flags[`DOG_TIMEOUT_RESET_FLAG_BIT_DBG];
  endproperty
  a_dbg_flag: assert property (p_dbg_flag)
    else $error("debug reset did not set its flag");

  property p_dog_flag;
    $rose(s.wdt_pulse) |-> s.flags[`DOG_TIMEOUT_RESET_FLAG_BIT_DOG] ##1 s.flags[`DOG_TIMEOUT_RESET_FLAG_BIT_DOG];
  endproperty
  a_dog_flag: assert property (p_dog_flag)
    else $error("watchdog reset did not set its flag");

  property p_bor_flag;
    src_s.bor |=> s.flags[`DOG_TIMEOUT_RESET_FLAG_BIT_BOR];
  endproperty
  a_bor_flag: assert property (p_bor_flag)
    else $error("brown-out reset did not set its flag");

  property p_pin_flag;
    src_s.ext |=> s.flags[`DOG_TIMEOUT_RESET_FLAG_BIT_PIN];
  endproperty
  a_pin_flag: assert property (p_pin_flag)
    else $error("pin reset did not set its flag");

  property p_por_flag;
    src_s.por |=> s.flags[`DOG_TIMEOUT_RESET_FLAG_BIT_POR];
  endproperty
  a_por_flag: assert property (p_por_flag)
    else $error("power-on reset did not set its flag");

  property p_por_clears;
    src_s.por && !src_s.dbg && !src_s.bor && !src_s.ext && !next_s.wdt_pulse
      |=> s.flags[4:1] == 4'h0;
  endproperty
  a_por_clears: assert property (p_por_clears)
    else $error("power-on reset left a cause flag set");

  property p_por_kept;
    s.flags[`DOG_TIMEOUT_RESET_FLAG_BIT_POR] && !(wr_stat && !apb_req.pwdata[`DOG_TIMEOUT_RESET_FLAG_BIT_POR])
      |=> s.flags[`DOG_TIMEOUT_RESET_FLAG_BIT_POR];
  endproperty
  a_por_kept: assert property (p_por_kept)
    else $error("power-on flag lost without a zero write");

  property p_restart;
    timer_restart_instruction |=> s.count == '0;
  endproperty
  a_restart: assert property (p_restart)
    else $error("restart did not zero the count");

  property p_pulse_one;
    s.wdt_pulse |=> !s.wdt_pulse && s.count == '0;
  endproperty
  a_pulse_one: assert property (p_pulse_one)
    else $error("watchdog reset pulse longer than one cycle");

  property p_level2_on;
    s.level2 |-> s.enable;
  endproperty
  a_level2_on: assert property (p_level2_on)
    else $error("safety level two watchdog got disabled");

  property p_unlock_len;
    $rose(unlock_on) |-> unlock_on [*4] ##1 !unlock_on;
  endproperty
  a_unlock_len: assert property (p_unlock_len)
    else $error("unlock window not four cycles");

  property p_locked_disable;
    s.enable && !unlock_on && wr_ctrl && !apb_req.pwdata[`DOG_TIMEOUT_RESET_FLAG_BIT_ENABLE] && !chip_rst
      |=> s.enable && $stable(s.sel);
  endproperty
  a_locked_disable: assert property (p_locked_disable)
    else $error("locked write changed the watchdog");

  property p_expiry;
    s.enable && !chip_rst && !timer_restart_instruction && osc_rise
      && ({1'b0, s.count} >= term) |=> s.wdt_pulse;
  endproperty
  a_expiry: assert property (p_expiry)
    else $error("expiry did not raise the reset pulse");

  // Guards of the counter and of the protected control register.
  property p_disable_zero;
    !s.enable |=> s.count == '0;
  endproperty
  a_disable_zero: assert property (p_disable_zero)
    else $error("disabled watchdog kept a count");

  property p_osc_tick;
    s.enable && !osc_rise && !chip_rst && !timer_restart_instruction |=> $stable(s.count);
  endproperty
  a_osc_tick: assert property (p_osc_tick)
    else $error("count moved without an oscillator tick");

  property p_chip_rst_ctrl;
    chip_rst |=> s.enable == s.level2 && s.sel == `DOG_TIMEOUT_RESET_FLAG_SEL_RST && !unlock_on;
  endproperty
  a_chip_rst_ctrl: assert property (p_chip_rst_ctrl)
    else $error("chip reset left the control register changed");

  property p_free_enable;
    wr_ctrl && apb_req.pwdata[`DOG_TIMEOUT_RESET_FLAG_BIT_ENABLE] && !chip_rst |=> s.enable;
  endproperty
  a_free_enable: assert property (p_free_enable)
    else $error("enable write did not enable the watchdog");

  property p_unlock_arm;
    wr_ctrl && apb_req.pwdata[`DOG_TIMEOUT_RESET_FLAG_BIT_UNLOCK] && apb_req.pwdata[`DOG_TIMEOUT_RESET_FLAG_BIT_ENABLE]
      && !chip_rst |=> s.unlock_ctr == `DOG_TIMEOUT_RESET_FLAG_UNLOCK_CYCLES;
  endproperty
  a_unlock_arm: assert property (p_unlock_arm)
    else $error("unlock write did not open the window");

  property p_timed_disable;
    !s.level2 && unlock_on && wr_ctrl && !apb_req.pwdata[`DOG_TIMEOUT_RESET_FLAG_BIT_ENABLE] && !chip_rst
      |=> !s.enable;
  endproperty
  a_timed_disable: assert property (p_timed_disable)
    else $error("timed disable left the watchdog enabled");

  property p_sel_locked;
    !unlock_on && !chip_rst |=> $stable(s.sel);
  endproperty
  a_sel_locked: assert property (p_sel_locked)
    else $error("period changed while locked");

  property p_sel_take;
    unlock_on && wr_ctrl && !chip_rst
      |=> s.sel == $past(apb_req.pwdata[`DOG_TIMEOUT_RESET_FLAG_SEL_HI:`DOG_TIMEOUT_RESET_FLAG_SEL_LO]);
  endproperty
  a_sel_take: assert property (p_sel_take)
    else $error("unlocked write did not set the period");

  property p_level2_read;
    s.level2 && access && !s.rsp.pready && !apb_req.pwrite
      && apb_req.paddr == `DOG_TIMEOUT_RESET_FLAG_OFS_CONTROL |=> s.rsp.prdata[`DOG_TIMEOUT_RESET_FLAG_BIT_ENABLE];
  endproperty
  a_level2_read: assert property (p_level2_read)
    else $error("safety level two enable read back as zero");

  property p_fuse_fixed;
    $stable(s.level2);
  endproperty
  a_fuse_fixed: assert property (p_fuse_fixed)
    else $error("safety level changed outside reset");

  c_timeout: cover property (s.wdt_pulse);
  c_unlock:  cover property ($rose(unlock_on));
  c_disable: cover property (s.enable ##1 !s.enable);
  c_por:     cover property (src_s.por ##1 s.flags[`DOG_TIMEOUT_RESET_FLAG_BIT_POR]);
  c_period:  cover property (unlock_on && wr_ctrl);

endmodule : dog_timeout_reset_flag_top

// >>> tb/dog_timeout_reset_flag_top_bench.sv
/*
  Self-checking bench of the watchdog and reset-cause block.
  Assumes the design files under rtl/ and dog_timeout_reset_flag_defs.svh on the include path.
*/
`include "dog_timeout_reset_flag_defs.svh"

module dog_timeout_reset_flag_top_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int BASE = 4;
  localparam logic [7:0] STAT = `DOG_TIMEOUT_RESET_FLAG_OFS_STATUS;
  localparam logic [7:0] CTRL = `DOG_TIMEOUT_RESET_FLAG_OFS_CONTROL;
  logic                    clk = 1'b0;
  logic                    rst = 1'b1;
  dog_timeout_reset_flag_pkg::dog_timeout_reset_flag_apb_req_t req = '0;
  dog_timeout_reset_flag_pkg::dog_timeout_reset_flag_apb_rsp_t rsp;
  dog_timeout_reset_flag_pkg::dog_timeout_reset_flag_src_t     src = '0;
  logic                    osc = 1'b0;
  logic                    fuse = 1'b0;
  logic                    rstr = 1'b0;
  logic                    pulse;
  int                      miscompares = 0;
  int                      samples_checked = 0;
  integer                  seed = 32'hbb3d8863;
  int                      osc_cnt = 0;
  int                      pulses = 0;
  int                      n;
  logic [31:0]             rd;
  logic                    err;
  logic [31:0]             e;
  logic [3:0]              srcv [3] = '{4'b1000, 4'b0100, 4'b0010};
  logic [31:0]             bitv [3] = '{32'h0000_0010, 32'h0000_0004, 32'h0000_0002};

  dog_timeout_reset_flag_top #(.BASE_CYCLES(BASE)) DUT (.clk(clk), .rst(rst), .apb_req(req), .apb_rsp(rsp),
    .reset_sources(src), .watchdog_osc(osc), .safety_level_fuse(fuse),
    .timer_restart_instruction(rstr), .watchdog_reset_pulse(pulse));

  always #12.5 clk = ~clk;

  // The watchdog oscillator toggles every 20 cycles, a 1 MHz rate.
  always @(posedge clk) begin
    osc_cnt <= (osc_cnt == 19) ? 0 : osc_cnt + 1;
    if (osc_cnt == 19) osc <= ~osc;
    if (pulse === 1'b1) pulses <= pulses + 1;
  end

  function automatic logic [31:0] ctrl_val(input logic en, input logic [2:0] sel);
    return {28'h000_0000, en, sel};
  endfunction : ctrl_val

  function automatic int limit(input logic [2:0] sel);
    return BASE << sel;
  endfunction : limit

  task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic cyc(input int c);
    repeat (c) @(posedge clk);
  endtask : cyc

  // Entered just after a rising edge; hold keeps psel up for a back-to-back transfer.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic hold);
    int k = 0;
    req.psel    <= 1'b1;
    req.penable <= 1'b0;
    req.pwrite  <= wr;
    req.paddr   <= a;
    req.pwdata  <= d | ({$random(seed)} & 32'hFFFF_FFE0);
    @(posedge clk);
    req.penable <= 1'b1;
    do begin
      @(posedge clk);
      k++;
    end while (rsp.pready !== 1'b1 && k < 20);
    check("pready", rsp.pready, 1'b1);
    rd  = rsp.prdata;
    err = rsp.pslverr;
    if (!hold) begin
      req.psel    <= 1'b0;
      req.penable <= 1'b0;
      @(posedge clk);
    end
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 1'b0);
  endtask : wr

  task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000, 1'b0);
    check(what, rd, exp);
  endtask : rchk

  task automatic src_pulse(input logic [3:0] s);
    src <= dog_timeout_reset_flag_pkg::dog_timeout_reset_flag_src_t'(s);
    cyc(4);
    src <= '0;
    cyc(4);
  endtask : src_pulse

  task automatic print_verdict();
    $display("Counts: %0d checked, %0d mismatched", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : print_verdict

  initial begin
    #(90000 * 25);
    miscompares++;
    print_verdict();
  end

  initial begin
    cyc(3);
    rst <= 1'b0;
    cyc(1);
    rchk("status at reset", STAT, 32'h0000_0001);
    rchk("control at reset", CTRL, ctrl_val(0, 0));
    apb(1'b0, 8'h08, 32'h0000_0000, 1'b0);
    check("unmapped error", err, 1'b1);
    e = 32'h0000_0001;
    for (int i = 0; i < 3; i++) begin
      src_pulse(srcv[i]);
      e = e | bitv[i];
      rchk("source flag", STAT, e);
    end
    wr(STAT, 32'h0000_001F);
    rchk("ones written", STAT, 32'h0000_0017);
    src_pulse(4'b0001);
    rchk("power-on clears", STAT, 32'h0000_0001);
    wr(STAT, 32'h0000_0000);
    rchk("flags cleared", STAT, 32'h0000_0000);
    $display("test flags done");
    wr(CTRL, ctrl_val(1, 0));
    rchk("enable free", CTRL, ctrl_val(1, 0));
    wr(CTRL, ctrl_val(0, 5));
    rchk("locked write", CTRL, ctrl_val(1, 0));
    wr(CTRL, 32'h0000_0018);
    cyc(6);
    rchk("unlock expired", CTRL, ctrl_val(1, 0));
    apb(1'b1, CTRL, 32'h0000_0010, 1'b1);
    wr(CTRL, 32'h0000_0000);
    rchk("half unlock", CTRL, ctrl_val(1, 0));
    $display("test control done");
    n = pulses;
    repeat (12) begin
      cyc(20 + {$random(seed)} % 60);
      rstr <= 1'b1;
      @(posedge clk);
      rstr <= 1'b0;
    end
    check("restart holds off", pulses - n, 0);
    $display("test restart done");
    for (int s = 0; s < 8; s++) begin
      apb(1'b1, CTRL, 32'h0000_0018, 1'b1);
      wr(CTRL, ctrl_val(0, s[2:0]));
      rchk("timed disable", CTRL, ctrl_val(0, s[2:0]));
      wr(CTRL, ctrl_val(1, s[2:0]));
      n = 0;
      while (pulse !== 1'b1 && n < 30000) begin
        @(posedge clk);
        n++;
      end
      check("expiry time", n >= (limit(s[2:0]) - 1) * 40 - 2 &&
            n <= limit(s[2:0]) * 40 + 10, 1);
      @(posedge clk);
      check("pulse width", pulse, 1'b0);
      rchk("dog flag", STAT, 32'h0000_0008);
      rchk("control after expiry", CTRL, ctrl_val(0, 0));
      wr(STAT, 32'h0000_0000);
    end
    $display("test timeout done");
    fuse <= 1'b1;
    cyc(3);
    rst <= 1'b1;
    cyc(3);
    rst <= 1'b0;
    fuse <= 1'b0;
    cyc(3);
    rchk("level two start", CTRL, ctrl_val(1, 0));
    apb(1'b1, CTRL, 32'h0000_0018, 1'b1);
    wr(CTRL, ctrl_val(0, 3));
    rchk("level two sequence", CTRL, ctrl_val(1, 3));
    $display("test level two done");
    print_verdict();
  end
endmodule : dog_timeout_reset_flag_top_bench
